// ==== core/ddrs_consts.svh ====
// Constants of the burst-of-four common-I/O static memory block.
// Assumes nothing; included by the package and by the beat buffer and core modules.
`ifndef DDRS_CONSTS_SVH
`define DDRS_CONSTS_SVH

// Organisation defaults: data width and burst address width of the x36 part
`define DDRS_DQ_W_DEF        36
`define DDRS_ADDR_W_DEF      18
`define DDRS_BYTE_W          9

// Burst: four beats, two address bits inside the burst
`define DDRS_BURST_AW        2
`define DDRS_BEAT_FIRST      2'h0
`define DDRS_BEAT_SECOND     2'h1
`define DDRS_BEAT_THIRD      2'h2
`define DDRS_BEAT_LAST       2'h3

// Output-edge schedules after a read command; bit 0 is the next output edge
`define DDRS_RD_SCHED        8'h3C
`define DDRS_RD_SCHED_DLLOFF 8'h1E
`define DDRS_SCHED_RST       8'h00

// Read beat buffer: two whole bursts
`define DDRS_FIFO_DEPTH      8

`endif

// ==== core/ddrs_pkg.sv ====
// Types shared by the memory core and its beat buffer.
// Assumes ddrs_consts.svh is on the include path.
`include "ddrs_consts.svh"

package ddrs_pkg;

   // Clock pins as they arrive from the controller
   typedef struct packed {
      logic k;
      logic k_n;
      logic c;
      logic c_n;
   } ddrs_clk_pins_t;

   // Command pins sampled on the command clock rising edge
   typedef struct packed {
      logic load_strobe_n;
      logic rd_wr;
   } ddrs_cmd_t;

   // Array fetch sequencer
   typedef enum logic [2:0] {
      FT_IDLE = 3'b001,
      FT_WAIT = 3'b010,
      FT_RUN  = 3'b100
   } ddrs_fetch_t;

endpackage : ddrs_pkg

// ==== core/ddrs_fifo.sv ====
// Beat buffer between the array fetch and the read data pins.
// Assumes one clock, synchronous active-low reset, same-domain handshakes.
`timescale 1ns/1ps
`default_nettype none
`include "ddrs_consts.svh"

module ddrs_fifo #(
   parameter int W     = `DDRS_DQ_W_DEF,
   parameter int DEPTH = `DDRS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   import ddrs_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  store_q [DEPTH];
   logic [AW:0]   wr_ptr_q;
   logic [AW:0]   rd_ptr_q;
   logic          push;
   logic          pop;

   assign in_ready  = (wr_ptr_q[AW] == rd_ptr_q[AW]) || (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]);
   assign out_valid = (wr_ptr_q != rd_ptr_q);
   assign out_data  = store_q[rd_ptr_q[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         store_q[wr_ptr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end

   default clocking fifo_cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   fifo_full_hold_a : assert property (!in_ready && !pop |=> !in_ready)
      else $error("beat buffer lost its full state without a pop");
   fifo_empty_a : assert property (!out_valid && !push |=> !out_valid)
      else $error("beat buffer shows data that was never pushed");

endmodule : ddrs_fifo
`default_nettype wire

// ==== core/ddrs_sram.sv ====
// Burst-of-four double-data-rate common-I/O static memory core.
// Assumes every pin comes from outside clk_sys and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "ddrs_consts.svh"

module ddrs_sram #(
   parameter int DQ_W   = `DDRS_DQ_W_DEF,
   parameter int ADDR_W = `DDRS_ADDR_W_DEF,
   parameter int BE_W   = DQ_W / `DDRS_BYTE_W
) (
   // System clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   // Command and output clock pins
   input  wire ddrs_pkg::ddrs_clk_pins_t clk_pins,
   input  wire logic                     dll_off_n,
   // Command pins
   input  wire ddrs_pkg::ddrs_cmd_t      cmd_in,
   input  wire logic [ADDR_W-1:0]        addr_in,
   // Write data pins
   input  wire logic [BE_W-1:0]          byte_write_en_n,
   input  wire logic [DQ_W-1:0]          dq_in,
   // Read data and echo clock pins
   output logic [DQ_W-1:0]               dq_out,
   output logic                          dq_oe_n,
   output logic                          echo_clk,
   output logic                          echo_clk_inv
);
   import ddrs_pkg::*;

   localparam int ARR_AW = ADDR_W + `DDRS_BURST_AW;
   localparam int CK_W   = $bits(ddrs_clk_pins_t);
   localparam int CMD_W  = $bits(ddrs_cmd_t);
   localparam int PIN_W  = CK_W + CMD_W + ADDR_W + BE_W + DQ_W + 1;

   // Pin synchroniser
   logic [PIN_W-1:0]   pin_s1_q;
   logic [PIN_W-1:0]   pin_s2_q;
   ddrs_clk_pins_t     ck_s;
   ddrs_cmd_t          cmd_s;
   logic [ADDR_W-1:0]  addr_s;
   logic [BE_W-1:0]    be_n_s;
   logic [DQ_W-1:0]    dq_s;
   logic               dll_off_n_s;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= {clk_pins, cmd_in, addr_in, byte_write_en_n, dq_in, dll_off_n};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign {ck_s, cmd_s, addr_s, be_n_s, dq_s, dll_off_n_s} = pin_s2_q;

   // Clock edge detection
   ddrs_clk_pins_t     ck_d1_q;
   logic               c_tied_q;
   logic               oc_d1;
   logic               ocn_d1;
   logic               k_rise;
   logic               kn_rise;
   logic               c_tied;
   logic               oc;
   logic               ocn;
   logic               out_edge;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ck_d1_q  <= '0;
         c_tied_q <= 1'b0;
      end else begin
         ck_d1_q  <= ck_s;
         c_tied_q <= ck_s.c && ck_s.c_n;
      end
   end

   assign k_rise   = ck_s.k && !ck_d1_q.k;
   assign kn_rise  = ck_s.k_n && !ck_d1_q.k_n;
   // Both output clocks high for two samples, not just a crossover
   assign c_tied   = c_tied_q && ck_s.c && ck_s.c_n;
   assign oc       = c_tied ? ck_s.k : ck_s.c;
   assign ocn      = c_tied ? ck_s.k_n : ck_s.c_n;
   // Edges against the previous level of the selected pair: a mode change makes none
   assign oc_d1    = c_tied ? ck_d1_q.k : ck_d1_q.c;
   assign ocn_d1   = c_tied ? ck_d1_q.k_n : ck_d1_q.c_n;
   assign out_edge = (oc && !oc_d1) || (ocn && !ocn_d1);

   // Command decode
   logic               cmd_v;
   logic               rd_cmd;
   logic               wr_cmd;

   assign cmd_v  = k_rise && !cmd_s.load_strobe_n;
   assign rd_cmd = cmd_v && cmd_s.rd_wr;
   assign wr_cmd = cmd_v && !cmd_s.rd_wr;

   // Late write: address buffer and beat capture
   logic               wr_pend_q;
   logic [ADDR_W-1:0]  pend_addr_q;
   logic               wr_act_q;
   logic [ADDR_W-1:0]  wr_addr_q;
   logic [1:0]         wr_idx_q;
   logic               wr_begin;
   logic               wr_stb;
   logic [1:0]         wr_beat;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_pend_q   <= 1'b0;
         pend_addr_q <= '0;
      end else if (wr_cmd) begin
         wr_pend_q   <= 1'b1;
         pend_addr_q <= addr_s;
      end else if (k_rise) begin
         wr_pend_q   <= 1'b0;
      end
   end

   assign wr_begin = k_rise && wr_pend_q;
   assign wr_stb   = wr_begin || (wr_act_q && (wr_idx_q[0] ? kn_rise : k_rise));
   assign wr_beat  = wr_begin ? `DDRS_BEAT_FIRST : wr_idx_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_act_q  <= 1'b0;
         wr_addr_q <= '0;
         wr_idx_q  <= `DDRS_BEAT_FIRST;
      end else if (wr_begin) begin
         wr_act_q  <= 1'b1;
         wr_addr_q <= pend_addr_q;
         wr_idx_q  <= `DDRS_BEAT_SECOND;
      end else if (wr_stb) begin
         wr_idx_q  <= wr_idx_q + 2'h1;
         if (wr_idx_q == `DDRS_BEAT_LAST) begin
            wr_act_q <= 1'b0;
         end
      end
   end

   // Memory array: byte-enabled write, registered read
   logic [DQ_W-1:0]    mem [2**ARR_AW];
   logic [DQ_W-1:0]    mem_rd_q;
   logic [ARR_AW-1:0]  wr_word;
   logic [ARR_AW-1:0]  rd_word;
   logic               rd_issue;

   assign wr_word = {(wr_begin ? pend_addr_q : wr_addr_q), wr_beat};

   always_ff @(posedge clk_sys) begin
      if (wr_stb) begin
         for (int b = 0; b < BE_W; b++) begin
            if (!be_n_s[b]) begin
               mem[wr_word][b*`DDRS_BYTE_W +: `DDRS_BYTE_W] <= dq_s[b*`DDRS_BYTE_W +: `DDRS_BYTE_W];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rd_issue) begin
         mem_rd_q <= mem[rd_word];
      end
   end

   // Read fetch: waits for buffered write beats, then four array reads
   logic               rd_pend_q;
   logic [ADDR_W-1:0]  rd_addr_q;
   ddrs_fetch_t        fst_q;
   logic [1:0]         fidx_q;
   logic               push_q;
   logic               fifo_in_ready;
   logic               fifo_out_valid;
   logic [DQ_W-1:0]    fifo_out_data;
   logic               fire;

   assign rd_word  = {rd_addr_q, fidx_q};
   assign rd_issue = (fst_q == FT_RUN) && !push_q && fifo_in_ready && !wr_stb;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_pend_q <= 1'b0;
         rd_addr_q <= '0;
      end else if (rd_cmd) begin
         rd_pend_q <= 1'b1;
         rd_addr_q <= addr_s;
      end else if (rd_issue && fidx_q == `DDRS_BEAT_LAST) begin
         rd_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fst_q  <= FT_IDLE;
         fidx_q <= `DDRS_BEAT_FIRST;
      end else begin
         unique case (fst_q)
            FT_IDLE: begin
               if (rd_pend_q) begin
                  fst_q <= FT_WAIT;
               end
            end
            FT_WAIT: begin
               if (!wr_pend_q && !wr_act_q && !wr_stb) begin
                  fst_q  <= FT_RUN;
                  fidx_q <= `DDRS_BEAT_FIRST;
               end
            end
            FT_RUN: begin
               if (rd_issue) begin
                  fidx_q <= fidx_q + 2'h1;
                  if (fidx_q == `DDRS_BEAT_LAST) begin
                     fst_q <= FT_IDLE;
                  end
               end
            end
            default: begin
               fst_q <= FT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         push_q <= 1'b0;
      end else begin
         push_q <= rd_issue;
      end
   end

   ddrs_fifo #(
      .W     (DQ_W),
      .DEPTH (`DDRS_FIFO_DEPTH)
   ) u_beat_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (push_q),
      .in_ready  (fifo_in_ready),
      .in_data   (mem_rd_q),
      .out_valid (fifo_out_valid),
      .out_ready (fire),
      .out_data  (fifo_out_data)
   );

   // Output schedule counted in output-clock edges after the command
   logic [7:0]         sched_q;
   logic [7:0]         sched_d;

   always_comb begin
      sched_d = out_edge ? (sched_q >> 1) : sched_q;
      if (rd_cmd) begin
         sched_d = sched_d | (dll_off_n_s ? `DDRS_RD_SCHED : `DDRS_RD_SCHED_DLLOFF);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sched_q <= `DDRS_SCHED_RST;
      end else begin
         sched_q <= sched_d;
      end
   end

   assign fire = out_edge && sched_q[0];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dq_out  <= '0;
         dq_oe_n <= 1'b1;
      end else if (out_edge) begin
         dq_oe_n <= !sched_q[0];
         if (fire && fifo_out_valid) begin
            dq_out <= fifo_out_data;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         echo_clk     <= 1'b0;
         echo_clk_inv <= 1'b1;
      end else begin
         echo_clk     <= oc;
         echo_clk_inv <= !oc;
      end
   end

   default clocking core_cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence wr_begin_s;
      k_rise && wr_pend_q;
   endsequence

   sequence wr_second_s;
      wr_act_q && wr_idx_q == `DDRS_BEAT_SECOND && kn_rise;
   endsequence

   wr_first_beat_a : assert property (wr_begin_s |=> wr_act_q && wr_idx_q == `DDRS_BEAT_SECOND)
      else $error("first write beat not taken on the next command clock rise");
   wr_addr_buf_a : assert property (wr_begin_s |=> wr_addr_q == $past(pend_addr_q))
      else $error("write address buffer does not hold the commanded address");
   wr_inv_beat_a : assert property (wr_second_s |=> wr_idx_q == `DDRS_BEAT_THIRD)
      else $error("second write beat not taken on the inverted clock rise");
   wr_true_beat_a : assert property (wr_act_q && wr_idx_q == `DDRS_BEAT_THIRD && k_rise |=> wr_idx_q == `DDRS_BEAT_LAST)
      else $error("third write beat not taken on the command clock rise");
   wr_done_a : assert property (wr_act_q && wr_idx_q == `DDRS_BEAT_LAST && kn_rise |=> !wr_act_q)
      else $error("write did not end after its fourth beat");
   rd_addr_take_a : assert property (rd_cmd |=> rd_pend_q && rd_addr_q == $past(addr_s))
      else $error("read address not sampled at the command edge");
   rd_sched_a : assert property (rd_cmd && dll_off_n_s |=> sched_q[5:2] == 4'hF)
      else $error("read beats not scheduled on output edges three to six");
   fetch_order_a : assert property (fst_q == FT_RUN |-> !wr_act_q && !wr_pend_q)
      else $error("array fetched while write beats still buffered");
   bus_float_a : assert property (out_edge && !sched_q[0] |=> dq_oe_n)
      else $error("data bus driven outside a read burst");
   echo_pair_a : assert property (echo_clk != echo_clk_inv)
      else $error("echo clocks not complementary");
   tied_clock_a : assert property (c_tied && k_rise |=> echo_clk && !echo_clk_inv)
      else $error("command clock rise not used as output edge when tied");

endmodule : ddrs_sram
`default_nettype wire

// ==== bench/ddrs_ctrl_model.sv ====
// Memory controller model: clock pins, commands, late write beats, read capture.
// Assumes clk_sys at 100 MHz; one k period is 16 clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module ddrs_ctrl_model #(
   parameter int DQ_W   = 36,
   parameter int ADDR_W = 6,
   parameter int BE_W   = 4
) (
   // Clock and output clock mode
   input  wire logic                clk_sys,
   input  wire logic                tie_c,
   input  wire logic                c_stop,
   // Pins toward the memory
   output ddrs_pkg::ddrs_clk_pins_t pins,
   output ddrs_pkg::ddrs_cmd_t      cmd,
   output logic [ADDR_W-1:0]        addr,
   output logic [BE_W-1:0]          be_n,
   output logic [DQ_W-1:0]          dq_drv,
   // Bus and echo clocks seen back
   input  wire logic [DQ_W-1:0]     dq_bus,
   input  wire logic                dq_oe_n,
   input  wire logic                echo_clk,
   input  wire logic                echo_clk_inv
);
   import ddrs_pkg::*;
   logic [3:0]      ph = 4'h0;
   logic            k = 1'b0;
   logic            drv = 1'b0;
   logic [DQ_W-1:0] wd = '0;
   logic [DQ_W-1:0] idle_q = '0;
   logic            echo_q = 1'b0;
   int              ecnt = 0;
   int              clash = 0;
   int              skew = 0;
   logic [DQ_W-1:0] rq[$];
   int              eq[$];
   int              es[$];

   // Released bus shows a pattern that flips every cycle
   always @(posedge clk_sys) ph <= ph + 4'h1;
   always @(posedge clk_sys) begin
      #1;
      k = ~ph[3];
      idle_q = ~idle_q;
   end
   assign pins = {k, ~k, tie_c | (k & ~c_stop), tie_c | (~k & ~c_stop)};
   assign dq_drv = drv ? wd : idle_q;
   initial begin
      cmd = '1;
      addr = '0;
      be_n = '1;
   end

   // Beats are taken on echo clock edges while the memory drives
   always @(negedge clk_sys) begin
      if (echo_clk !== echo_q) begin
         ecnt = ecnt + 1;
         if (dq_oe_n === 1'b0) begin
            rq.push_back(dq_bus);
            eq.push_back(ecnt);
         end
      end
      echo_q = echo_clk;
      if (echo_clk_inv !== ~echo_clk) skew = skew + 1;
      if (drv && dq_oe_n === 1'b0) clash = clash + 1;
   end

   task automatic at(input logic [3:0] n);
      do begin
         @(posedge clk_sys);
         #1;
      end while (ph != n);
   endtask : at

   // Command held four cycles either side of its k rise
   task automatic issue(input logic rd, input logic ld, input logic [ADDR_W-1:0] a);
      at(4'hC);
      cmd = {ld, rd};
      addr = a;
      at(4'h4);
      cmd = '1;
      addr = ~a;
   endtask : issue

   task automatic write(input logic [ADDR_W-1:0] a, input logic [3:0][DQ_W-1:0] d,
                        input logic [3:0][BE_W-1:0] b, input logic ld);
      issue(1'b0, ld, a);
      for (int i = 0; i < 4; i++) begin
         if (i == 2) at(4'hC);
         else if (i > 0) at(4'h4);
         wd = d[i];
         be_n = b[i];
         drv = 1'b1;
      end
      at(4'hC);
      drv = 1'b0;
      be_n = '1;
   endtask : write

   task automatic read(input logic [ADDR_W-1:0] a);
      issue(1'b1, 1'b0, a);
      at(4'h8);
      es.push_back(ecnt);
      at(4'hC);
   endtask : read
endmodule : ddrs_ctrl_model
`default_nettype wire

// ==== bench/tb_ddr_burst4_common_io_sram.sv ====
// Testbench of the burst-of-four memory core and of its beat buffer.
// Assumes ddrs_ctrl_model stands in for the memory controller.
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_burst4_common_io_sram;
   import ddrs_pkg::*;
   localparam int DQ_W   = 36;
   localparam int ADDR_W = 6;
   localparam int BE_W   = 4;
   typedef logic [3:0][DQ_W-1:0] ddrs_burst_t;
   logic              clk_sys = 1'b0;
   logic              rst_n = 1'b0;
   logic              dll_off_n = 1'b1;
   logic              tie_c = 1'b0;
   ddrs_clk_pins_t    pins;
   ddrs_cmd_t         cmd;
   logic [ADDR_W-1:0] addr;
   logic [BE_W-1:0]   be_n;
   logic [DQ_W-1:0]   dq_drv;
   logic [DQ_W-1:0]   dq_out;
   logic [DQ_W-1:0]   dq_bus;
   logic              dq_oe_n;
   logic              echo_clk;
   logic              echo_clk_inv;
   logic              c_stop = 1'b0;
   logic [DQ_W-1:0]   sh[2**(ADDR_W+2)];
   logic [ADDR_W-1:0] rdq[$];
   ddrs_burst_t       d1;
   int                miscompares = 0;
   int                num_checks = 0;

   always #5 clk_sys = ~clk_sys;
   assign dq_bus = (dq_oe_n === 1'b0) ? dq_out : dq_drv;

   ddrs_sram #(.DQ_W(DQ_W), .ADDR_W(ADDR_W)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_pins(pins),
      .dll_off_n(dll_off_n), .cmd_in(cmd), .addr_in(addr), .byte_write_en_n(be_n), .dq_in(dq_bus),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .echo_clk(echo_clk), .echo_clk_inv(echo_clk_inv));
   ddrs_ctrl_model #(.DQ_W(DQ_W), .ADDR_W(ADDR_W), .BE_W(BE_W)) ctrl_u (.clk_sys(clk_sys), .tie_c(tie_c),
      .c_stop(c_stop), .pins(pins), .cmd(cmd), .addr(addr), .be_n(be_n), .dq_drv(dq_drv), .dq_bus(dq_bus),
      .dq_oe_n(dq_oe_n), .echo_clk(echo_clk), .echo_clk_inv(echo_clk_inv));

   task automatic chk_d(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_d

   task automatic chk_n(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_n

   // Shadow keeps the newest bytes; a read may follow at the next legal k rise
   task automatic wr(input logic [ADDR_W-1:0] a, input ddrs_burst_t d, input logic [3:0][BE_W-1:0] b,
                     input logic ld, input bit rd_after);
      for (int i = 0; i < 4; i++)
         for (int j = 0; j < BE_W; j++)
            if (!ld && !b[i][j]) sh[{a, i[1:0]}][j*9+:9] = d[i][j*9+:9];
      if (rd_after) rdq.push_back(a);
      fork
         ctrl_u.write(a, d, b, ld);
         if (rd_after) begin
            ctrl_u.at(4'hC);
            ctrl_u.at(4'hC);
            ctrl_u.read(a);
         end
      join
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a);
      rdq.push_back(a);
      ctrl_u.read(a);
   endtask : rd

   // Waits for every pending burst, then checks data and output-edge position
   task automatic chk_rd(input int lat);
      int n;
      int e0;
      logic [ADDR_W-1:0] a;
      n = 0;
      while (ctrl_u.rq.size() < 4 * rdq.size() && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (32) @(posedge clk_sys);
      #1;
      chk_n(ctrl_u.rq.size(), 4 * rdq.size());
      while (rdq.size() > 0 && ctrl_u.es.size() > 0 && ctrl_u.rq.size() > 3) begin
         a = rdq.pop_front();
         e0 = ctrl_u.es.pop_front();
         for (int i = 0; i < 4; i++) begin
            chk_d(ctrl_u.rq.pop_front(), sh[{a, i[1:0]}]);
            chk_n(ctrl_u.eq.pop_front() - e0, lat + i);
         end
      end
      rdq.delete();
   endtask : chk_rd

   task automatic t_reset;
      chk_d(dq_out, '0);
      chk_d(DQ_W'({dq_oe_n, echo_clk, echo_clk_inv}), DQ_W'(3'b101));
   endtask : t_reset

   // Stopped output clocks let two bursts fill the beat buffer; a reset in mid-run empties it
   task automatic t_fifo;
      int n;
      n = ctrl_u.rq.size();
      c_stop = 1'b1;
      ctrl_u.read(6'h05);
      ctrl_u.read(6'h3F);
      repeat (64) @(posedge clk_sys);
      #1;
      chk_n(ctrl_u.rq.size() - n, 0);
      chk_d(DQ_W'(dq_oe_n), DQ_W'(1'b1));
      rst_n = 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      chk_d(DQ_W'({dq_oe_n, echo_clk, echo_clk_inv}), DQ_W'(3'b101));
      rst_n = 1'b1;
      c_stop = 1'b0;
      ctrl_u.es.delete();
      repeat (32) @(posedge clk_sys);
      #1;
   endtask : t_fifo

   task automatic t_burst;
      d1 = {36'hC_3C3C_3C33, 36'h5_A5A5_A5A2, 36'hF_0F0F_0F01, 36'h1_2345_6780};
      wr(6'h05, d1, '0, 1'b0, 1'b1);
      chk_rd(3);
      wr(6'h3F, ~d1, '0, 1'b0, 1'b0);
      rd(6'h3F);
      chk_rd(3);
   endtask : t_burst

   task automatic t_bytes;
      wr(6'h05, ~d1, {4'h7, 4'hB, 4'hD, 4'hE}, 1'b0, 1'b1);
      chk_rd(3);
   endtask : t_bytes

   task automatic t_noload;
      wr(6'h05, '0, '0, 1'b1, 1'b0);
      rd(6'h05);
      rd(6'h3F);
      chk_rd(3);
   endtask : t_noload

   task automatic t_modes;
      tie_c = 1'b1;
      repeat (32) @(posedge clk_sys);
      rd(6'h3F);
      chk_rd(3);
      tie_c = 1'b0;
      dll_off_n = 1'b0;
      repeat (32) @(posedge clk_sys);
      rd(6'h05);
      chk_rd(2);
      dll_off_n = 1'b1;
   endtask : t_modes

   task automatic t_idle;
      int e;
      e = ctrl_u.ecnt;
      repeat (64) @(posedge clk_sys);
      chk_n(ctrl_u.ecnt - e, 8);
      chk_n(ctrl_u.skew, 0);
      chk_n(ctrl_u.clash, 0);
   endtask : t_idle

   task automatic test_done;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   initial begin
      #200000;
      miscompares++;
      test_done;
   end

   initial begin
      repeat (7) @(posedge clk_sys);
      #1;
      t_reset;
      @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      t_fifo;
      t_burst;
      t_bytes;
      t_noload;
      t_modes;
      t_idle;
      test_done;
   end
endmodule : tb_ddr_burst4_common_io_sram
`default_nettype wire
